// File: hdl/mrbcb_pkg.sv
/*
  constants of the modem rate / bandwidth configuration bank:
  register indices, byte addresses, reset values, writable masks, field positions, modulation codes.
  assumes a 32-bit avalon-mm slave port with byte addresses, one register per aligned word.
*/
package mrbcb_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam int          REG_COUNT    = 5;
  localparam int          BUS_AW       = 8;
  localparam logic [5:0]  IDX_CW_MID   = 6'h0E;
  localparam logic [5:0]  IDX_CW_LOW   = 6'h0F;
  localparam logic [5:0]  IDX_BW_RATE  = 6'h10;
  localparam logic [5:0]  IDX_RATE_MAN = 6'h11;
  localparam logic [5:0]  IDX_MOD_FILT = 6'h12;
  localparam logic [7:0]  ADDR_CW_MID   = {IDX_CW_MID, 2'h0};
  localparam logic [7:0]  ADDR_CW_LOW   = {IDX_CW_LOW, 2'h0};
  localparam logic [7:0]  ADDR_BW_RATE  = {IDX_BW_RATE, 2'h0};
  localparam logic [7:0]  ADDR_RATE_MAN = {IDX_RATE_MAN, 2'h0};
  localparam logic [7:0]  ADDR_MOD_FILT = {IDX_MOD_FILT, 2'h0};

  // slot order inside the bank
  localparam int SLOT_CW_MID   = 0;
  localparam int SLOT_CW_LOW   = 1;
  localparam int SLOT_BW_RATE  = 2;
  localparam int SLOT_RATE_MAN = 3;
  localparam int SLOT_MOD_FILT = 4;

  localparam logic [5:0] SLOT_INDEX [REG_COUNT] = '{IDX_CW_MID, IDX_CW_LOW, IDX_BW_RATE, IDX_RATE_MAN, IDX_MOD_FILT};
  localparam logic [7:0] SLOT_RESET [REG_COUNT] = '{8'hC4, 8'hEC, 8'h8C, 8'h22, 8'h00};
  localparam logic [7:0] SLOT_MASK  [REG_COUNT] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF0};

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int BW_EXP_LSB   = 6;
  localparam int BW_MANT_LSB  = 4;
  localparam int RATE_EXP_LSB = 0;
  localparam int DC_BYPASS_POS = 7;
  localparam int MOD_SEL_LSB  = 4;
  localparam int CW_HIGH_W    = 6;

  // ---------------------------------------------------------------------------
  // modulation codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] MOD_FSK  = 3'h0;
  localparam logic [2:0] MOD_GFSK = 3'h1;
  localparam logic [2:0] MOD_ASK  = 3'h3;
  localparam logic [2:0] MOD_MSK  = 3'h7;

  // ---------------------------------------------------------------------------
  // derived-rate arithmetic
  // ---------------------------------------------------------------------------
  localparam logic [2:0] BW_BASE_MANT = 3'h4;
  localparam logic [2:0] BW_PRESHIFT  = 3'h3;
  localparam int         DECIM_W      = 9;
  localparam int         RATE_STEP_W  = 24;

endpackage

// File: hdl/mrbcb_reg_if.sv
/*
  carrier between the bus decoder and one configuration byte store.
  assumes the decoder drives the write strobe for at most one store at a time.
*/
interface mrbcb_reg_if;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] q;

  modport bank  (output wr, output wdata, input q);
  modport store (input wr, input wdata, output q);
endinterface

// File: hdl/mrbcb_cfg_reg.sv
/*
  one 8-bit configuration byte with a reset value and a mask of writable bits.
  assumes synchronous active-high reset; bits outside the mask always read zero.
*/
module mrbcb_cfg_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  input  wire logic     clock,
  input  wire logic     sys_rst,
  mrbcb_reg_if.store    port
);

  logic [7:0] value;
  logic [7:0] next_value;

  always_comb
  begin
    next_value = port.wr ? (port.wdata & WR_MASK) : value;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      value <= RESET_VAL & WR_MASK;
    else
      value <= next_value;
  end

  assign port.q = value;

endmodule

// File: hdl/mrbcb_top.sv
/*
  modem rate / bandwidth configuration bank: carrier word middle and low bytes,
  channel filter bandwidth, symbol rate, dc blocking control and modulation select,
  with an avalon-mm slave (waitrequest) and registered decoded outputs for the modem.
  the bus answers every access after exactly one wait cycle; a write lands at the edge
  that ends it and the decoded outputs follow one edge later. unmapped reads return zero,
  unmapped writes are dropped with normal timing, reserved bits of the modulation byte read zero.
  assumes the carrier word high byte comes from a neighbouring register on carrier_word_high,
  that only byte lane 0 of the data word carries a register, that the master holds each
  request until it sees waitrequest low, and a synchronous active-high sys_rst.
*/
// What this block does
// - middle carrier byte at 0x0E, reset C4
// - low carrier byte at 0x0F, reset EC
// - bandwidth decimation from exponent and mantissa fields
// - rate exponent bits 3:0, reset 1100
// - dc filter on when bypass bit clear
// - modulation select bits 6:4, FSK/GFSK codes
// - carrier word is 24 bits, high byte below
// - carrier bits 23:22 always read zero
module mrbcb_top
  import mrbcb_pkg::*;
#(
  parameter int ADDR_W = BUS_AW
) (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // register bus
  input  wire logic [ADDR_W-1:0]       avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // neighbouring high byte in, decoded configuration out
  input  wire logic [7:0]              carrier_word_high,
  output logic      [23:0]             carrier_word,
  output logic      [1:0]              bandwidth_exponent,
  output logic      [1:0]              bandwidth_mantissa,
  output logic      [3:0]              rate_exponent,
  output logic      [7:0]              rate_mantissa,
  output logic                         dc_block_enable,
  output logic      [2:0]              modulation_select,
  output logic                         mod_is_fsk,
  output logic                         mod_is_gfsk,
  output logic                         mod_is_ask,
  output logic                         mod_is_msk,
  // derived divider settings
  output logic      [DECIM_W-1:0]      decim_ratio,
  output logic      [RATE_STEP_W-1:0]  rate_step
);

  // ---------------------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------------------
  if (ADDR_W != BUS_AW)
    $error("mrbcb_top: ADDR_W must equal the register map address width");
  if (REG_COUNT > (1 << (BUS_AW - 2)))
    $error("mrbcb_top: register map larger than the address space");
  if (CW_HIGH_W + 2 != 8)
    $error("mrbcb_top: carrier high part must leave bits 23:22 free");
  if (BW_EXP_LSB != BW_MANT_LSB + 2 || BW_MANT_LSB != RATE_EXP_LSB + 4)
    $error("mrbcb_top: bandwidth and rate fields do not tile their byte");
  if (DC_BYPASS_POS != MOD_SEL_LSB + 3)
    $error("mrbcb_top: dc bypass bit must sit above the modulation field");

  // a reset value must not set bits that software cannot write
  for (genvar c = 0; c < REG_COUNT; c++)
  begin : gen_check
    if ((SLOT_RESET[c] & ~SLOT_MASK[c]) != 8'h00)
      $error("mrbcb_top: reset value sets bits that are not writable");
  end

  // ---------------------------------------------------------------------------
  // bus handshake state
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {
    MRBCB_IDLE,
    MRBCB_DONE
  } mrbcb_state_t;

  mrbcb_state_t       state;
  mrbcb_state_t       next_state;
  logic [31:0]        next_readdata;
  logic [5:0]         req_index;
  logic [REG_COUNT-1:0] hit;
  logic [7:0]         reg_q [REG_COUNT];
  logic [7:0]         sel_q;
  logic               req_any;
  logic               wr_take;
  logic [REG_COUNT-1:0] wr_hit;

  assign req_any   = avs_read | avs_write;
  // byte address bits 1:0 are ignored
  assign req_index = avs_address[7:2];
  // request stalls one cycle, then completes
  assign avs_waitrequest = req_any && (state == MRBCB_IDLE);
  assign wr_take   = avs_write && (state == MRBCB_DONE) && avs_byteenable[0];

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  always_comb
  begin
    // an unmapped index matches no slot and reads zero
    sel_q = 8'h00;
    for (int i = 0; i < REG_COUNT; i++)
    begin
      hit[i] = (req_index == SLOT_INDEX[i]);
      if (hit[i])
        sel_q = reg_q[i];
    end
  end

  // ---------------------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------------------
  // lane 0 carries the register; a write without it completes but stores nothing
  always_comb
  begin
    for (int i = 0; i < REG_COUNT; i++)
    begin
      wr_hit[i] = wr_take && hit[i];
    end
  end

  // ---------------------------------------------------------------------------
  // bus handshake and read data
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_state    = state;
    next_readdata = avs_readdata;
    unique case (state)
      MRBCB_IDLE:
      begin
        if (req_any)
        begin
          next_state = MRBCB_DONE;
          // unmapped reads return zero
          next_readdata = avs_read ? {24'h000000, sel_q} : 32'h00000000;
        end
      end
      MRBCB_DONE:
      begin
        // always back to idle: each access takes two cycles
        next_state = MRBCB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state        <= MRBCB_IDLE;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      state        <= next_state;
      avs_readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------------------
  // register stores
  // ---------------------------------------------------------------------------
  mrbcb_reg_if reg_bus [REG_COUNT] ();

  for (genvar g = 0; g < REG_COUNT; g++)
  begin : gen_reg
    assign reg_bus[g].wr    = wr_hit[g];
    assign reg_bus[g].wdata = avs_writedata[7:0];
    assign reg_q[g]         = reg_bus[g].q;

    mrbcb_cfg_reg #(
      .RESET_VAL (SLOT_RESET[g]),
      .WR_MASK   (SLOT_MASK[g])
    ) u_reg (
      .clock   (clock),
      .sys_rst (sys_rst),
      .port    (reg_bus[g])
    );
  end

  // ---------------------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------------------
  logic [1:0] f_bw_exp;
  logic [1:0] f_bw_mant;
  logic [3:0] f_rate_exp;
  logic [7:0] f_rate_mant;
  logic       f_dc_bypass;
  logic [2:0] f_mod_sel;

  assign f_bw_exp    = reg_q[SLOT_BW_RATE][BW_EXP_LSB +: 2];
  assign f_bw_mant   = reg_q[SLOT_BW_RATE][BW_MANT_LSB +: 2];
  assign f_rate_exp  = reg_q[SLOT_BW_RATE][RATE_EXP_LSB +: 4];
  assign f_rate_mant = reg_q[SLOT_RATE_MAN];
  assign f_dc_bypass = reg_q[SLOT_MOD_FILT][DC_BYPASS_POS];
  assign f_mod_sel   = reg_q[SLOT_MOD_FILT][MOD_SEL_LSB +: 3];

  // ---------------------------------------------------------------------------
  // decoded output stage
  // ---------------------------------------------------------------------------
  logic [23:0] next_carrier_word;
  logic        next_dc_block_enable;
  logic        next_is_fsk;
  logic        next_is_gfsk;
  logic        next_is_ask;
  logic        next_is_msk;
  logic [1:0]  next_bandwidth_exponent;
  logic [1:0]  next_bandwidth_mantissa;
  logic [3:0]  next_rate_exponent;
  logic [7:0]  next_rate_mantissa;
  logic [2:0]  next_modulation_select;

  always_comb
  begin
    next_carrier_word = {2'b00, carrier_word_high[CW_HIGH_W-1:0], reg_q[SLOT_CW_MID], reg_q[SLOT_CW_LOW]};
    next_bandwidth_exponent = f_bw_exp;
    next_bandwidth_mantissa = f_bw_mant;
    next_rate_exponent      = f_rate_exp;
    next_rate_mantissa      = f_rate_mant;
    next_dc_block_enable = ~f_dc_bypass;
    next_modulation_select  = f_mod_sel;
    next_is_fsk  = (f_mod_sel == MOD_FSK);
    next_is_gfsk = (f_mod_sel == MOD_GFSK);
    next_is_ask  = (f_mod_sel == MOD_ASK);
    next_is_msk  = (f_mod_sel == MOD_MSK);
  end

  // one register stage between the stored bytes and the modem
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      carrier_word       <= 24'h000000;
      bandwidth_exponent <= 2'h0;
      bandwidth_mantissa <= 2'h0;
      rate_exponent      <= 4'h0;
      rate_mantissa      <= 8'h00;
      dc_block_enable    <= 1'b0;
      modulation_select  <= 3'h0;
      mod_is_fsk         <= 1'b0;
      mod_is_gfsk        <= 1'b0;
      mod_is_ask         <= 1'b0;
      mod_is_msk         <= 1'b0;
    end
    else
    begin
      carrier_word       <= next_carrier_word;
      bandwidth_exponent <= next_bandwidth_exponent;
      bandwidth_mantissa <= next_bandwidth_mantissa;
      rate_exponent      <= next_rate_exponent;
      rate_mantissa      <= next_rate_mantissa;
      dc_block_enable    <= next_dc_block_enable;
      modulation_select  <= next_modulation_select;
      mod_is_fsk         <= next_is_fsk;
      mod_is_gfsk        <= next_is_gfsk;
      mod_is_ask         <= next_is_ask;
      mod_is_msk         <= next_is_msk;
    end
  end

  // ---------------------------------------------------------------------------
  // decimation and rate arithmetic
  // ---------------------------------------------------------------------------
  mrbcb_rate_calc #(
    .DECIM_WIDTH (DECIM_W),
    .STEP_WIDTH  (RATE_STEP_W)
  ) u_rate_calc (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .bw_exp      (f_bw_exp),
    .bw_mant     (f_bw_mant),
    .rate_exp    (f_rate_exp),
    .rate_mant   (f_rate_mant),
    .decim_ratio (decim_ratio),
    .rate_step   (rate_step)
  );

endmodule

// File: hdl/mrbcb_rate_calc.sv
/*
  registered channel-filter decimation ratio and symbol-rate step for the modem.
  assumes the modem scales rate_step by the crystal frequency over 2^28.
*/
module mrbcb_rate_calc
  import mrbcb_pkg::*;
#(
  parameter int DECIM_WIDTH = DECIM_W,
  parameter int STEP_WIDTH  = RATE_STEP_W
) (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic [1:0]              bw_exp,
  input  wire logic [1:0]              bw_mant,
  input  wire logic [3:0]              rate_exp,
  input  wire logic [7:0]              rate_mant,
  output logic      [DECIM_WIDTH-1:0]  decim_ratio,
  output logic      [STEP_WIDTH-1:0]   rate_step
);

  if (DECIM_WIDTH < DECIM_W || STEP_WIDTH < RATE_STEP_W)
    $error("mrbcb_rate_calc: output widths too narrow for the largest settings");

  logic [DECIM_WIDTH-1:0] next_decim;
  logic [STEP_WIDTH-1:0]  next_step;

  always_comb
  begin
    next_decim = DECIM_WIDTH'({1'b0, BW_BASE_MANT} + {2'b00, bw_mant}) << (BW_PRESHIFT + {1'b0, bw_exp});
    next_step  = STEP_WIDTH'({1'b1, rate_mant}) << rate_exp;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      decim_ratio <= '0;
      rate_step   <= '0;
    end
    else
    begin
      decim_ratio <= next_decim;
      rate_step   <= next_step;
    end
  end

endmodule

// File: bench/mrbcb_top_assertions.sv
/*
  port checker of the configuration bank: bus timing, field decodes, write-to-output latency.
  assumes it is bound into mrbcb_top with the default 8-bit byte address.
*/
module mrbcb_top_assertions
  import mrbcb_pkg::*;
(
  input wire logic                    clock,
  input wire logic                    sys_rst,
  input wire logic [7:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  input wire logic [7:0]              carrier_word_high,
  input wire logic [23:0]             carrier_word,
  input wire logic [1:0]              bandwidth_exponent,
  input wire logic [1:0]              bandwidth_mantissa,
  input wire logic [3:0]              rate_exponent,
  input wire logic [7:0]              rate_mantissa,
  input wire logic                    dc_block_enable,
  input wire logic [2:0]              modulation_select,
  input wire logic                    mod_is_fsk,
  input wire logic                    mod_is_gfsk,
  input wire logic                    mod_is_ask,
  input wire logic                    mod_is_msk,
  input wire logic [DECIM_W-1:0]      decim_ratio,
  input wire logic [RATE_STEP_W-1:0]  rate_step
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------------------
  // bus and outputs
  // ---------------------------------------------------------------------------
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not after one wait cycle");
  property p_upper_zero;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits not zero");
  property p_top_bits;
    carrier_word[23:22] == 2'h0;
  endproperty
  a_top_bits: assert property (p_top_bits)
    else $error("carrier bits 23:22 not zero");
  property p_high_track;
    !$past(sys_rst) |-> carrier_word[21:16] == $past(carrier_word_high[5:0]);
  endproperty
  a_high_track: assert property (p_high_track)
    else $error("carrier high bits do not follow input");
  property p_decim;
    !$past(sys_rst) |-> decim_ratio == 9'((32 + 8 * bandwidth_mantissa) << bandwidth_exponent);
  endproperty
  a_decim: assert property (p_decim)
    else $error("decimation ratio wrong");
  property p_rate;
    !$past(sys_rst) |-> rate_step == 24'((256 + rate_mantissa) << rate_exponent);
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate step wrong");
  property p_decode;
    !$past(sys_rst) |-> mod_is_fsk == (modulation_select == MOD_FSK) && mod_is_gfsk == (modulation_select == MOD_GFSK)
      && mod_is_ask == (modulation_select == MOD_ASK) && mod_is_msk == (modulation_select == MOD_MSK);
  endproperty
  a_decode: assert property (p_decode)
    else $error("modulation decode wrong");
  property p_mid_write;
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[7:2] == IDX_CW_MID
      |=> ##1 carrier_word[15:8] == $past(avs_writedata[7:0], 2);
  endproperty
  a_mid_write: assert property (p_mid_write)
    else $error("middle carrier byte not written");
  property p_mod_write;
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[7:2] == IDX_MOD_FILT
      |=> ##1 dc_block_enable == !$past(avs_writedata[7], 2) && modulation_select == $past(avs_writedata[6:4], 2);
  endproperty
  a_mod_write: assert property (p_mod_write)
    else $error("dc or modulation field not written");
  property p_low_read;
    avs_read && !avs_waitrequest && avs_address[7:2] == IDX_CW_LOW |-> avs_readdata[7:0] == carrier_word[7:0];
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("low carrier byte read mismatch");
endmodule

bind mrbcb_top mrbcb_top_assertions u_chk (
  .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .carrier_word_high(carrier_word_high), .carrier_word(carrier_word),
  .bandwidth_exponent(bandwidth_exponent), .bandwidth_mantissa(bandwidth_mantissa),
  .rate_exponent(rate_exponent), .rate_mantissa(rate_mantissa), .dc_block_enable(dc_block_enable),
  .modulation_select(modulation_select), .mod_is_fsk(mod_is_fsk), .mod_is_gfsk(mod_is_gfsk),
  .mod_is_ask(mod_is_ask), .mod_is_msk(mod_is_msk), .decim_ratio(decim_ratio), .rate_step(rate_step));

// File: bench/mrbcb_top_test.sv
/*
  self-checking bench of the configuration bank over its avalon-mm port.
  assumes the bank answers every request after one wait cycle.
*/
module mrbcb_top_test
  import mrbcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, dc_en, fsk, gfsk, ask, msk;
  logic [7:0] avs_address, cw_high, rate_man;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, rate_exp;
  logic [23:0] cw, rate_step;
  logic [1:0] bw_exp, bw_man;
  logic [2:0] mod_sel;
  logic [8:0] decim;
  int n_fail, cmp_count;
  logic [7:0] addr_tab [5] = '{ADDR_CW_MID, ADDR_CW_LOW, ADDR_BW_RATE, ADDR_RATE_MAN, ADDR_MOD_FILT};
  logic [7:0] rst_tab [5] = '{8'hC4, 8'hEC, 8'h8C, 8'h22, 8'h00};

  mrbcb_top u_dut (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .carrier_word_high(cw_high),
    .carrier_word(cw), .bandwidth_exponent(bw_exp), .bandwidth_mantissa(bw_man), .rate_exponent(rate_exp),
    .rate_mantissa(rate_man), .dc_block_enable(dc_en), .modulation_select(mod_sel), .mod_is_fsk(fsk),
    .mod_is_gfsk(gfsk), .mod_is_ask(ask), .mod_is_msk(msk), .decim_ratio(decim), .rate_step(rate_step));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task compare(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one access: request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      compare(1'b0, 1'b1, "bus timeout");
      print_verdict;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task settle;
    @(posedge clock);
    @(negedge clock);
  endtask

  task t_reset_values;
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, addr_tab[i], 8'h00, 4'hF);
      compare(rd, {24'h0, rst_tab[i]}, "reset value");
    end
    compare(cw, {2'h0, cw_high[5:0], 16'hC4EC}, "carrier reset");
    compare({dc_en, fsk, gfsk, ask, msk, mod_sel, bw_exp, bw_man, rate_exp, rate_man},
      {2'h3, 6'h00, 8'h8C, 8'h22}, "field reset");
    compare(decim, 9'h080, "decimation reset");
    compare(rate_step, 24'h122000, "rate step reset");
    $display("test reset values done");
  endtask

  task t_carrier;
    cw_high <= 8'hEA;
    bus(1'b1, ADDR_CW_MID, 8'h5A, 4'h1);
    bus(1'b1, ADDR_CW_LOW | 8'h03, 8'hA5, 4'hF);
    bus(1'b1, ADDR_CW_MID, 8'h11, 4'hE);
    settle;
    compare(cw, 24'h2A5AA5, "carrier word");
    bus(1'b0, ADDR_CW_MID, 8'h00, 4'hF);
    compare(rd, 32'h5A, "mid readback");
    bus(1'b0, ADDR_CW_LOW, 8'h00, 4'hF);
    compare(rd, 32'hA5, "low readback");
    $display("test carrier done");
  endtask

  task t_rate;
    logic [7:0] m, d;
    for (int i = 0; i < 16; i++)
    begin
      m = 8'(i * 17);
      d = {i[3:0], 4'(15 - i)};
      bus(1'b1, ADDR_RATE_MAN, m, 4'h1);
      bus(1'b1, ADDR_BW_RATE, d, 4'h1);
      settle;
      compare(decim, 9'((32 + 8 * i[1:0]) << i[3:2]), "decimation");
      compare(rate_step, 24'((256 + m) << (15 - i)), "rate step");
      compare({bw_exp, bw_man, rate_exp, rate_man}, {d, m}, "rate fields");
      bus(1'b0, ADDR_BW_RATE, 8'h00, 4'hF);
      compare(rd, {24'h0, d}, "bw rate readback");
    end
    $display("test rate done");
  endtask

  task t_modulation;
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      // the if setting to rewrite sits outside this bank
      bus(1'b1, ADDR_MOD_FILT, {c[0], c, 4'hF}, 4'h1);
      settle;
      compare({dc_en, mod_sel}, {~c[0], c}, "dc and modulation");
      compare({fsk, gfsk, ask, msk}, {c == 3'h0, c == 3'h1, c == 3'h3, c == 3'h7}, "decode");
      bus(1'b0, ADDR_MOD_FILT, 8'h00, 4'hF);
      compare(rd, {24'h0, c[0], c, 4'h0}, "mod readback");
    end
    $display("test modulation done");
  endtask

  task t_unmapped;
    bus(1'b1, 8'h4C, 8'hFF, 4'hF);
    bus(1'b0, 8'h4C, 8'h00, 4'hF);
    compare(rd, 32'h0, "unmapped read");
    bus(1'b0, 8'h34, 8'h00, 4'hF);
    compare(rd, 32'h0, "unmapped read");
    $display("test unmapped done");
  endtask

  initial
  begin
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    cw_high = 8'hFF;
    n_fail = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset_values;
    t_carrier;
    t_rate;
    t_modulation;
    t_unmapped;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset_values;
    print_verdict;
  end
endmodule
